// ==== common/ssg_defines.svh ====
// Constants for the superframe sync and guard timing block
// ****************************************************************
// ****************************************************************
`ifndef SSG_DEFINES_SVH
`define SSG_DEFINES_SVH

// Widths
`define SSG_TW            20
`define SSG_AW            8
`define SSG_DW            32
`define SSG_SLOT_W        8
`define SSG_MISS_W        4

// Clock and time base
`define SSG_CLK_NS        100
`define SSG_RES_NS        1000
`define SSG_RES_CYC       ((`SSG_RES_NS + `SSG_CLK_NS - 1) / `SSG_CLK_NS)
`define SSG_SF_TICKS_DEF  65536
`define SSG_TOL_PPM       20
`define SSG_LOST_LIMIT    3
`define SSG_MAX_STEP      4
`define SSG_ALIGN_ERR_MUL 2
`define SSG_DRIFT_MUL     2
`define SSG_PPM_SCALE     1000000
`define SSG_SIFS_NS       2500
`define SSG_SIFS_TICKS    ((`SSG_SIFS_NS + `SSG_RES_NS - 1) / `SSG_RES_NS)
`define SSG_SLOT_TICKS    100
`define SSG_BP_SLOTS      16
`define SSG_BP_END        (`SSG_SLOT_TICKS * `SSG_BP_SLOTS)

// Register offsets
`define SSG_REG_CTRL      8'h00
`define SSG_REG_STATUS    8'h04
`define SSG_REG_CORR      8'h08
`define SSG_REG_GUARD     8'h0c
`define SSG_REG_TIME      8'h10

// Control fields and reset value
`define SSG_CTRL_EN       0
`define SSG_CTRL_SEC      1
`define SSG_CTRL_SLAVE    2
`define SSG_CTRL_HIB      3
`define SSG_CTRL_W        4
`define SSG_CTRL_RST      4'h1

// Status fields
`define SSG_ST_FORCED     0
`define SSG_ST_LOCKED     1
`define SSG_ST_PWR_LSB    2
`define SSG_ST_MISS_LSB   4

`endif

// ==== common/ssg_pkg.sv ====
// Types shared by the superframe sync and guard timing block
`include "ssg_defines.svh"
package ssg_pkg;
  typedef logic [`SSG_TW-1:0]        ssg_tick_type;
  typedef logic signed [`SSG_TW-1:0] ssg_off_type;

  // Received beacon report from the PHY front end
  typedef struct packed {
    logic                   valid;
    ssg_tick_type           arrival;
    logic [`SSG_SLOT_W-1:0] slot;
    logic                   from_sec;
    logic                   forced;
    logic                   sig_slot;
  } ssg_bcn_type;

  // Master poll frame timing for slave operation
  typedef struct packed {
    logic         valid;
    ssg_tick_type time_ref;
  } ssg_poll_type;

  // Reservation and availability windows from the scheduler
  typedef struct packed {
    ssg_tick_type rsv_start;
    ssg_tick_type rsv_end;
    ssg_tick_type avail_start;
    ssg_tick_type avail_end;
  } ssg_win_type;

  // Transmit fit query
  typedef struct packed {
    logic         valid;
    ssg_tick_type len;
    ssg_tick_type ack_len;
    logic         imm_ack;
    logic         last_back;
  } ssg_fit_type;

  // Power state, Gray coded along the wake path
  typedef enum logic [1:0] {
    SSG_HIB   = 2'h0,
    SSG_WAIT  = 2'h1,
    SSG_ALIGN = 2'h3,
    SSG_RUN   = 2'h2
  } ssg_pwr_type;
endpackage

// ==== hw/ssg_top.sv ====
// Superframe synchronisation and guard timing for one beaconing device
`include "ssg_defines.svh"
module ssg_top #(
  parameter int SF_TICKS = `SSG_SF_TICKS_DEF
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  // Register port
  input  wire logic [`SSG_AW-1:0]    reg_addr,
  input  wire logic [`SSG_DW-1:0]    reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [`SSG_DW-1:0]    reg_rdata,
  // Receive side reports
  input  wire ssg_pkg::ssg_bcn_type  bcn_rx,
  input  wire ssg_pkg::ssg_poll_type poll_rx,
  // Scheduler windows and transmit query
  input  wire ssg_pkg::ssg_win_type  win,
  input  wire ssg_pkg::ssg_fit_type  fit_req,
  output logic                       fit_valid,
  output logic                       fit_ok,
  // Timing outputs
  output logic                       rx_listen,
  output logic                       bp_start,
  output logic                       bcn_forced_sync,
  output logic                       bcn_tx_allowed,
  output ssg_pkg::ssg_tick_type      sf_time
);

  // ****************************************************************
  // Derived timing constants
  // ****************************************************************
  localparam ssg_pkg::ssg_tick_type SF_LAST = ssg_pkg::ssg_tick_type'(SF_TICKS - 1);
  localparam ssg_pkg::ssg_tick_type BP_END  = ssg_pkg::ssg_tick_type'(`SSG_BP_END);
  localparam ssg_pkg::ssg_tick_type SLOT_T  = ssg_pkg::ssg_tick_type'(`SSG_SLOT_TICKS);
  localparam ssg_pkg::ssg_tick_type SIFS_T  = ssg_pkg::ssg_tick_type'(`SSG_SIFS_TICKS);
  localparam ssg_pkg::ssg_off_type  STEP_P  = ssg_pkg::ssg_off_type'(`SSG_MAX_STEP);
  localparam ssg_pkg::ssg_off_type  STEP_N  = ssg_pkg::ssg_off_type'(-`SSG_MAX_STEP);
  localparam logic [7:0]            DIV_LAST = 8'(`SSG_RES_CYC - 1);
  localparam logic [`SSG_MISS_W-1:0] LOST_LIM = `SSG_MISS_W'(`SSG_LOST_LIMIT);
  // drift over the alignment interval, rounded up to ticks
  localparam longint ALIGN_IVL = longint'(`SSG_LOST_LIMIT + 1) * longint'(SF_TICKS);
  localparam longint DRIFT_T   = (longint'(`SSG_DRIFT_MUL) * `SSG_TOL_PPM * ALIGN_IVL
                                  + `SSG_PPM_SCALE - 1) / `SSG_PPM_SCALE;
  // guard is alignment error plus drift
  localparam ssg_pkg::ssg_tick_type GUARD_T =
    ssg_pkg::ssg_tick_type'(longint'(`SSG_ALIGN_ERR_MUL) + DRIFT_T);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_r;
  logic rst_sync_r;

  // Release is synchronised so all flops leave reset on the same edge
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ****************************************************************
  // Control register and resolution tick
  // ****************************************************************
  logic [`SSG_CTRL_W-1:0] ctrl_r;
  logic [7:0]             div_r;
  logic                   tick_r;
  logic                   en_w;
  logic                   sec_w;
  logic                   slave_w;
  logic                   hib_w;
  ssg_pkg::ssg_pwr_type   pwr_r;

  assign en_w    = ctrl_r[`SSG_CTRL_EN];
  assign sec_w   = ctrl_r[`SSG_CTRL_SEC];
  assign slave_w = ctrl_r[`SSG_CTRL_SLAVE];
  assign hib_w   = ctrl_r[`SSG_CTRL_HIB];

  // Software writes of the control word
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ctrl_r <= `SSG_CTRL_RST;
    end else if (reg_wr && reg_addr == `SSG_REG_CTRL) begin
      ctrl_r <= reg_wdata[`SSG_CTRL_W-1:0];
    end
  end

  // one tick per resolution step of the time base
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end else if (div_r == DIV_LAST) begin
      div_r  <= 8'h00;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 8'h01;
      tick_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Superframe counter
  // ****************************************************************
  ssg_pkg::ssg_tick_type sf_cnt_r;
  ssg_pkg::ssg_tick_type sf_end_r;
  logic                  wrap_w;
  logic                  decide_w;

  assign wrap_w   = tick_r && sf_cnt_r >= sf_end_r;
  assign decide_w = tick_r && sf_cnt_r == BP_END;

  // counter zero marks the beacon period start reference
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sf_cnt_r <= '0;
    end else if (slave_w && poll_rx.valid) begin
      sf_cnt_r <= poll_rx.time_ref;
    end else if (wrap_w) begin
      sf_cnt_r <= '0;
    end else if (tick_r) begin
      sf_cnt_r <= sf_cnt_r + ssg_pkg::ssg_tick_type'(1);
    end
  end

  // ****************************************************************
  // Neighbour offset measurement
  // ****************************************************************
  ssg_pkg::ssg_tick_type expect_w;
  ssg_pkg::ssg_off_type  off_w;
  logic                  use_w;
  logic                  sec_ok_w;

  assign expect_w = ssg_pkg::ssg_tick_type'(bcn_rx.slot) * SLOT_T;
  assign off_w    = ssg_pkg::ssg_off_type'(bcn_rx.arrival - expect_w);
  assign use_w    = bcn_rx.valid && !bcn_rx.sig_slot && en_w && !slave_w
                    && pwr_r != ssg_pkg::SSG_HIB;
  // secondary devices only hear secondary neighbours for timing
  assign sec_ok_w = !sec_w || bcn_rx.from_sec;

  ssg_pkg::ssg_off_type sec_max_r;
  ssg_pkg::ssg_off_type fs_off_r;
  ssg_pkg::ssg_off_type pri_max_r;
  logic                 have_sec_r;
  logic                 have_fs_r;
  logic                 have_pri_r;

  // Per-superframe candidates, cleared at each start reference
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sec_max_r  <= '0;
      fs_off_r   <= '0;
      pri_max_r  <= '0;
      have_sec_r <= 1'b0;
      have_fs_r  <= 1'b0;
      have_pri_r <= 1'b0;
    end else begin
      if (wrap_w) begin
        have_sec_r <= 1'b0;
        have_fs_r  <= 1'b0;
        have_pri_r <= 1'b0;
      end
      if (use_w && sec_ok_w) begin // A beacon in the wrap cycle wins over the clear
        // slowest secondary kept as largest positive offset
        if (bcn_rx.from_sec && (!have_sec_r || wrap_w || off_w > sec_max_r)) begin
          sec_max_r  <= off_w;
          have_sec_r <= 1'b1;
        end
        if (!bcn_rx.from_sec && bcn_rx.forced && (!have_fs_r || wrap_w)) begin
          fs_off_r  <= off_w;
          have_fs_r <= 1'b1;
        end
        if (!bcn_rx.from_sec && (!have_pri_r || wrap_w || off_w > pri_max_r)) begin
          pri_max_r  <= off_w;
          have_pri_r <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Neighbour choice and correction
  // ****************************************************************
  ssg_pkg::ssg_off_type sel_w;
  logic                 have_w;
  logic                 forced_w;
  ssg_pkg::ssg_off_type sat_w;

  // Pick the neighbour to follow for this superframe
  always_comb begin
    sel_w    = '0;
    have_w   = 1'b0;
    forced_w = 1'b0;
    if (pwr_r == ssg_pkg::SSG_ALIGN) begin
      // waking device follows slowest clock heard
      have_w = have_sec_r || have_pri_r;
      if (have_sec_r && (!have_pri_r || sec_max_r > pri_max_r)) begin
        sel_w = sec_max_r;
      end else begin
        sel_w = pri_max_r;
      end
      forced_w = !sec_w && have_sec_r;
    end else if (sec_w) begin
      have_w = have_sec_r;
      sel_w  = sec_max_r;
    end else if (have_sec_r) begin
      have_w   = 1'b1;
      sel_w    = sec_max_r;
      forced_w = 1'b1;
    end else if (have_fs_r) begin
      have_w = 1'b1;
      sel_w  = fs_off_r;
    end else begin
      have_w = have_pri_r;
      sel_w  = pri_max_r;
    end
  end

  // saturate the signed step before use
  assign sat_w = (sel_w > STEP_P) ? STEP_P : (sel_w < STEP_N) ? STEP_N : sel_w;

  ssg_pkg::ssg_off_type   corr_r;
  ssg_pkg::ssg_off_type   hist_r;
  logic [`SSG_MISS_W-1:0] miss_r;
  logic                   forced_r;
  logic                   locked_r;

  // Decision at the end of the beacon period, end point moved in place
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      sf_end_r <= SF_LAST;
      corr_r   <= '0;
      hist_r   <= '0;
      miss_r   <= '0;
      forced_r <= 1'b0;
      locked_r <= 1'b0;
    end else if (wrap_w) begin
      sf_end_r <= SF_LAST;
    end else if (decide_w && !slave_w) begin
      forced_r <= forced_w;
      if (have_w) begin
        // positive offset delays start, negative advances it
        // capped step lands before this superframe closes
        sf_end_r <= SF_LAST + ssg_pkg::ssg_tick_type'(sat_w);
        corr_r   <= sat_w;
        hist_r   <= sat_w;
        miss_r   <= '0;
        locked_r <= 1'b1;
      end else if (miss_r < LOST_LIM && locked_r) begin
        // extrapolate from the last measured step
        sf_end_r <= SF_LAST + ssg_pkg::ssg_tick_type'(hist_r);
        corr_r   <= hist_r;
        miss_r   <= miss_r + `SSG_MISS_W'(1);
      end else begin
        corr_r   <= '0;
        locked_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Hibernation wake sequence
  // ****************************************************************
  // after hibernation a full aligning superframe precedes any beacon; reset starts in SSG_RUN
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pwr_r <= ssg_pkg::SSG_RUN;
    end else if (hib_w) begin
      pwr_r <= ssg_pkg::SSG_HIB;
    end else begin
      case (pwr_r)
        ssg_pkg::SSG_HIB:   pwr_r <= ssg_pkg::SSG_WAIT;
        ssg_pkg::SSG_WAIT:  if (wrap_w) pwr_r <= ssg_pkg::SSG_ALIGN;
        ssg_pkg::SSG_ALIGN: if (wrap_w) pwr_r <= ssg_pkg::SSG_RUN;
        ssg_pkg::SSG_RUN:   pwr_r <= ssg_pkg::SSG_RUN;
        default:            pwr_r <= ssg_pkg::SSG_HIB;
      endcase
    end
  end

  // ****************************************************************
  // Listen windows and transmit fit check
  // ****************************************************************
  logic                  lis_w;
  ssg_pkg::ssg_tick_type need_w;
  ssg_pkg::ssg_tick_type ahead_w;

  assign ahead_w = sf_cnt_r + GUARD_T;

  // open the receiver one guard early
  // same guard at beacon period and block edges
  assign lis_w = en_w && pwr_r != ssg_pkg::SSG_HIB && (
                   sf_cnt_r <= BP_END || ahead_w > sf_end_r
                   || (ahead_w >= win.rsv_start && sf_cnt_r < win.rsv_end)
                   || (ahead_w >= win.avail_start && sf_cnt_r < win.avail_end));

  // acked frames add ack and two short spaces
  always_comb begin
    need_w = fit_req.len + SIFS_T + GUARD_T;
    if (fit_req.imm_ack || fit_req.last_back) begin
      need_w = need_w + fit_req.ack_len + SIFS_T + SIFS_T;
    end
  end

  logic fit_valid_r;
  logic fit_ok_r;
  logic lis_r;
  logic bp_start_r;

  // Answers registered so every output leaves a flop
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      fit_valid_r <= 1'b0;
      fit_ok_r    <= 1'b0;
      lis_r       <= 1'b0;
      bp_start_r  <= 1'b0;
    end else begin
      fit_valid_r <= fit_req.valid;
      // start allowed exactly at the block start
      fit_ok_r    <= fit_req.valid && sf_cnt_r >= win.rsv_start
                     && sf_cnt_r + need_w <= win.rsv_end;
      lis_r       <= lis_w;
      bp_start_r  <= wrap_w;
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  logic [`SSG_DW-1:0] rdata_r;
  logic [`SSG_DW-1:0] status_w;

  always_comb begin
    status_w = '0;
    status_w[`SSG_ST_FORCED] = forced_r;
    status_w[`SSG_ST_LOCKED] = locked_r;
    status_w[`SSG_ST_PWR_LSB +: 2] = pwr_r;
    status_w[`SSG_ST_MISS_LSB +: `SSG_MISS_W] = miss_r;
  end

  // Read data stands for the one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `SSG_REG_CTRL:   rdata_r <= `SSG_DW'(ctrl_r);
        `SSG_REG_STATUS: rdata_r <= status_w;
        `SSG_REG_CORR:   rdata_r <= `SSG_DW'(signed'(corr_r));
        `SSG_REG_GUARD:  rdata_r <= `SSG_DW'(GUARD_T);
        `SSG_REG_TIME:   rdata_r <= `SSG_DW'(sf_cnt_r);
        default:         rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // Beacon flags registered apart from the decision logic
  logic bcn_fs_r;
  logic bcn_ok_r;

  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      bcn_fs_r <= 1'b0;
      bcn_ok_r <= 1'b0;
    end else begin
      // force-aligned flag carried in every beacon
      bcn_fs_r <= forced_r;
      bcn_ok_r <= en_w && pwr_r == ssg_pkg::SSG_RUN;
    end
  end

  assign reg_rdata       = rdata_r;
  assign fit_valid       = fit_valid_r;
  assign fit_ok          = fit_ok_r;
  assign rx_listen       = lis_r;
  assign bp_start        = bp_start_r;
  assign bcn_forced_sync = bcn_fs_r;
  assign bcn_tx_allowed  = bcn_ok_r;
  assign sf_time         = sf_cnt_r;

endmodule // ssg_top

// ==== sim/ssg_nbr_model.sv ====
// Neighbour beacon model driving the receive report port
`include "ssg_defines.svh"
module ssg_nbr_model (
  // Clock and local time base
  input wire logic                  mclk,
  input wire ssg_pkg::ssg_tick_type sf_time,
  // Beacon reports towards the block
  output ssg_pkg::ssg_bcn_type      bcn_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  initial bcn_rx = '0;
  // Beacon lands at slot start plus off ticks; calls come in rising order
  task automatic send(input int slot, input int off, input logic sec, input logic frc,
                      input logic sig);
    int t;
    t = slot * `SSG_SLOT_TICKS + off;
    for (int k = 0; k < 30000 && int'(sf_time) != t; k++) @(posedge mclk);
    bcn_rx <= '{valid:1'b1, arrival:20'(t), slot:8'(slot), from_sec:sec, forced:frc,
                sig_slot:sig};
    @(posedge mclk);
    // Released report no longer shows the last beacon
    bcn_rx <= '{valid:1'b0, arrival:~bcn_rx.arrival, slot:~bcn_rx.slot, default:1'b0};
  endtask
endmodule // ssg_nbr_model

// ==== sim/ssg_properties.sv ====
// Concurrent checks on the superframe sync block ports
`include "ssg_defines.svh"
module ssg_properties #(
  parameter int SF_TICKS = `SSG_SF_TICKS_DEF
) (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  rstn,
  // Observed ports
  input wire ssg_pkg::ssg_win_type  win,
  input wire ssg_pkg::ssg_fit_type  fit_req,
  input wire ssg_pkg::ssg_poll_type poll_rx,
  input wire logic                  fit_valid,
  input wire logic                  fit_ok,
  input wire logic                  rx_listen,
  input wire logic                  bp_start,
  input wire logic                  bcn_tx_allowed,
  input wire ssg_pkg::ssg_tick_type sf_time
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SIFS = `SSG_SIFS_TICKS;
  localparam int GD = `SSG_ALIGN_ERR_MUL + (`SSG_DRIFT_MUL * `SSG_TOL_PPM *
    (`SSG_LOST_LIMIT + 1) * SF_TICKS + `SSG_PPM_SCALE - 1) / `SSG_PPM_SCALE;
  logic [2:0] live_r;
  int         need;
  int         room;
  // Mirror the two-flop reset release, one edge of margin on top
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      live_r <= '0;
    end else begin
      live_r <= {live_r[1:0], 1'b1};
    end
  end
  // Time a query needs against the room left in the block
  assign room = int'(win.rsv_end) - int'(sf_time);
  assign need = int'(fit_req.len) + SIFS + GD + ((fit_req.imm_ack || fit_req.last_back) ?
                int'(fit_req.ack_len) + 2 * SIFS : 0);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!live_r[2]);
  a_fit_answer: assert property (fit_req.valid |=> fit_valid)
    else $error("fit answer missing");
  a_fit_quiet: assert property (!fit_req.valid |=> !fit_valid)
    else $error("fit answer without query");
  a_fit_early: assert property (fit_req.valid && sf_time < win.rsv_start |=> !fit_ok)
    else $error("fit granted before block start");
  a_fit_room: assert property (fit_req.valid && sf_time >= win.rsv_start && need <= room
    |=> fit_ok)
    else $error("fitting frame refused");
  a_fit_short: assert property (fit_req.valid && need > room |=> !fit_ok)
    else $error("frame granted without room");
  a_tick_hold: assert property ($changed(sf_time) && !$past(poll_rx.valid) |=>
    ($stable(sf_time) || $past(poll_rx.valid)) [*8])
    else $error("tick shorter than resolution");
  a_tick_step: assert property ($changed(sf_time) && sf_time != '0
    && !$past(poll_rx.valid) |-> sf_time - $past(sf_time) == 20'h00001)
    else $error("counter jumped");
  a_bp_wrap: assert property ($changed(sf_time) && sf_time == '0
    && !$past(poll_rx.valid) |-> ##[0:1] bp_start)
    else $error("no start pulse at wrap");
  a_bp_single: assert property (bp_start |=> !bp_start)
    else $error("start pulse too long");
  a_bp_listen: assert property (sf_time < `SSG_BP_END && bcn_tx_allowed |=> rx_listen)
    else $error("deaf in beacon period");
  cover property (fit_valid && fit_ok);
  cover property (fit_valid && !fit_ok);
  cover property (bp_start && bcn_tx_allowed);
endmodule // ssg_properties

bind ssg_top ssg_properties #(.SF_TICKS(SF_TICKS)) u_props (
  .mclk(mclk), .rstn(rstn), .win(win), .fit_req(fit_req), .poll_rx(poll_rx),
  .fit_valid(fit_valid),
  .fit_ok(fit_ok), .rx_listen(rx_listen), .bp_start(bp_start),
  .bcn_tx_allowed(bcn_tx_allowed), .sf_time(sf_time));

// ==== sim/testbench.sv ====
// Self-checking bench for the superframe sync block
`include "ssg_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // Short superframe keeps four of them inside the run
  localparam int SFT = 2000;
  localparam int S   = `SSG_SIFS_TICKS;
  localparam int GD  = 2 + (2 * `SSG_TOL_PPM * (`SSG_LOST_LIMIT + 1) * SFT + 999999) / 1000000;
  logic                  mclk, rstn, reg_wr, reg_rd;
  logic                  fit_valid, fit_ok, rx_listen, bp_start, frc, tx_ok;
  logic [`SSG_AW-1:0]    reg_addr;
  logic [`SSG_DW-1:0]    reg_wdata, reg_rdata, rv;
  ssg_pkg::ssg_bcn_type  bcn_rx;
  ssg_pkg::ssg_poll_type poll_rx;
  ssg_pkg::ssg_win_type  win;
  ssg_pkg::ssg_fit_type  fit_req;
  ssg_pkg::ssg_tick_type sf_time;
  int                    err_total, n_tests, cyc, t0;

  ssg_top #(.SF_TICKS(SFT)) u_dut (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bcn_rx(bcn_rx),
    .poll_rx(poll_rx), .win(win), .fit_req(fit_req), .fit_valid(fit_valid), .fit_ok(fit_ok),
    .rx_listen(rx_listen), .bp_start(bp_start), .bcn_forced_sync(frc),
    .bcn_tx_allowed(tx_ok), .sf_time(sf_time));
  ssg_nbr_model u_nbr (.mclk(mclk), .sf_time(sf_time), .bcn_rx(bcn_rx));

  // Clock and cycle count
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string w);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string w);
    chk_word({31'h0, got}, {31'h0, exp}, w);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string w);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk_word(rv & m, e, w);
  endtask
  // Wait for a tick value, then let registered outputs settle
  task automatic wait_tick(input int t);
    for (int k = 0; k < 30000 && int'(sf_time) != t; k++) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  task automatic wait_bp();
    for (int k = 0; k < 25000 && bp_start !== 1'b1; k++) @(posedge mclk);
    @(posedge mclk);
  endtask
  // Query launched on a fresh tick so the time seen is known
  task automatic fit(input int so, input int eo, input int len, input int ack,
                     input logic ia, input logic lb, input logic e, input string w);
    int t;
    t = int'(sf_time);
    for (int k = 0; k < 20 && int'(sf_time) == t; k++) @(posedge mclk);
    t = int'(sf_time);
    win <= '{rsv_start:20'(t + so), rsv_end:20'(t + eo), avail_start:'0, avail_end:'0};
    fit_req <= '{valid:1'b1, len:20'(len), ack_len:20'(ack), imm_ack:ia, last_back:lb};
    @(posedge mclk);
    fit_req.valid <= 1'b0;
    @(posedge mclk);
    chk_bit(fit_valid, 1'b1, "fit answer");
    chk_bit(fit_ok, e, w);
  endtask

  task automatic t_regs();
    rchk(`SSG_REG_CTRL, 32'hffffffff, 32'h1, "ctrl reset");
    rchk(`SSG_REG_GUARD, 32'hffffffff, 32'(GD), "guard");
    wr(`SSG_REG_STATUS, 32'hffffffff);
    rchk(`SSG_REG_STATUS, 32'hffffffff, 32'h8, "status");
    rchk(8'h20, 32'hffffffff, 32'h0, "unmapped");
  endtask
  // Exact fits and one-tick misses for no-ack and immediate-ack frames, only a one-tick miss for last_back
  task automatic t_fit();
    fit(0, 10 + S + GD, 10, 0, 1'b0, 1'b0, 1'b1, "noack exact");
    fit(0, 9 + S + GD, 10, 0, 1'b0, 1'b0, 1'b0, "noack short");
    fit(1, 99, 10, 0, 1'b0, 1'b0, 1'b0, "before start");
    fit(0, 15 + 3 * S + GD, 10, 5, 1'b1, 1'b0, 1'b1, "imm exact");
    fit(0, 14 + 3 * S + GD, 10, 5, 1'b1, 1'b0, 1'b0, "imm short");
    fit(0, 14 + 3 * S + GD, 10, 5, 1'b0, 1'b1, 1'b0, "back short");
    fit(0, 14 + 3 * S + GD, 10, 5, 1'b0, 1'b0, 1'b1, "ack unused");
  endtask
  task automatic t_listen();
    wait_tick(1700);
    win <= '{rsv_start:20'(1710), rsv_end:20'(1720), avail_start:20'(1710),
             avail_end:20'(1720)};
    wait_tick(1709 - GD);
    chk_bit(rx_listen, 1'b0, "listen early");
    wait_tick(1710 - GD);
    chk_bit(rx_listen, 1'b1, "listen on time");
  endtask
  // Hibernate, then wake through a waiting and an aligning superframe
  task automatic t_wake();
    wr(`SSG_REG_CTRL, 32'h9);
    rchk(`SSG_REG_STATUS, 32'hd, 32'h0, "asleep");
    wr(`SSG_REG_CTRL, 32'h1);
    rchk(`SSG_REG_STATUS, 32'hd, 32'h4, "waiting");
    wait_bp();
    rchk(`SSG_REG_STATUS, 32'hd, 32'hc, "aligning");
    chk_bit(tx_ok, 1'b0, "no beacon yet");
    wait_bp();
    t0 = cyc;
    rchk(`SSG_REG_STATUS, 32'hd, 32'h8, "running");
    chk_bit(tx_ok, 1'b1, "beacon allowed");
  endtask
  // Slowest secondary beats signalling-slot, forced and primary beacons
  task automatic t_follow_slow();
    u_nbr.send(1, 4, 1'b1, 1'b0, 1'b1);
    u_nbr.send(2, 1, 1'b1, 1'b0, 1'b0);
    u_nbr.send(3, 3, 1'b1, 1'b0, 1'b0);
    u_nbr.send(4, 2, 1'b0, 1'b1, 1'b0);
    u_nbr.send(5, 4, 1'b0, 1'b0, 1'b0);
    wait_tick(1602);
    rchk(`SSG_REG_CORR, 32'hffffffff, 32'h3, "slow offset");
    rchk(`SSG_REG_STATUS, 32'hd, 32'h9, "forced status");
    chk_bit(frc, 1'b1, "forced flag");
    wait_bp();
    chk_word(32'(cyc - t0), 32'((SFT + 3) * 10), "delayed start");
    t0 = cyc;
  endtask
  // Faster neighbour beyond the step limit
  task automatic t_follow_fast();
    u_nbr.send(5, -6, 1'b1, 1'b0, 1'b0);
    wait_tick(1602);
    rchk(`SSG_REG_CORR, 32'hffffffff, 32'hfffffffc, "capped step");
    wait_bp();
    chk_word(32'(cyc - t0), 32'((SFT - 4) * 10), "advanced start");
  endtask
  // Slave mode loads the counter from a master poll
  task automatic t_slave();
    wr(`SSG_REG_CTRL, 32'h5);
    poll_rx <= '{valid:1'b1, time_ref:20'h004d2};
    @(posedge mclk);
    poll_rx.valid <= 1'b0;
    #1 chk_word(32'(sf_time), 32'h4d2, "poll load");
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Reset, then the scenarios in superframe order
  initial begin
    rstn = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    win = '0;
    fit_req = '0;
    poll_rx = '0;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    t0 = 0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_fit();
    t_listen();
    t_wake();
    t_follow_slow();
    t_follow_fast();
    t_slave();
    give_verdict();
  end
  // Four superframes need about 80000 cycles; beyond 90000 it hangs
  initial begin
    repeat (90000) @(posedge mclk);
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule // testbench
